// *** pkg/ascii_link_pkg.sv ***
// constants and state type for the ascii parameter link engine
package ascii_link_pkg;
  // ------------------------------------------------------------
  // character framing and control codes
  // ------------------------------------------------------------
  localparam int          CHAR_W   = 7;
  localparam logic [6:0]  EOT_C    = 7'h04;
  localparam logic [6:0]  ENQ_C    = 7'h05;
  localparam logic [6:0]  STX_C    = 7'h02;
  localparam logic [6:0]  ETX_C    = 7'h03;
  localparam logic [6:0]  ACK_C    = 7'h06;
  localparam logic [6:0]  NAK_C    = 7'h15;
  localparam logic [6:0]  BS_C     = 7'h08;
  localparam logic [6:0]  DIGIT_0  = 7'h30;
  localparam logic [6:0]  DIGIT_9  = 7'h39;
  localparam logic [6:0]  BCC_LIFT = 7'h20;
  // ------------------------------------------------------------
  // message geometry and mode setting
  // ------------------------------------------------------------
  localparam int          DATA_MAX   = 7;
  localparam logic [2:0]  ADDR_LAST  = 3'h3;
  localparam logic [2:0]  PARAM_LAST = 3'h3;
  localparam logic [3:0]  TX_DATA0   = 4'h5;
  localparam logic [1:0]  MODE_ASCII = 2'h0;
  localparam logic [1:0]  MODE_RTU   = 2'h1;
  // ------------------------------------------------------------
  // engine states
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_ADDR  = 4'h1,
    ST_POST  = 4'h2,
    ST_PARAM = 4'h3,
    ST_ENQ   = 4'h4,
    ST_DATA  = 4'h5,
    ST_BCC   = 4'h6,
    ST_RDW   = 4'h7,
    ST_WRW   = 4'h8,
    ST_TX    = 4'h9,
    ST_DRAIN = 4'hA
  } state_t;
endpackage

// *** hdl/ascii_param_link_engine.sv ***
// message engine of the ascii parameter serial protocol
// Contract
// - check char is xor of all chars after start-of-text through end-of-text.
// - accumulator loads first char after start-of-text, then xors each next.
// - xor result below 32 gets 32 added.
// - after valid read reply, nak/ack/bs re-reads same/next/previous parameter.
// - full write: eot, group x2, unit x2, stx, 4 digits, data, etx, check.
// - write data field variable, at most seven characters.
// - nak for too long data, bad parameter, read-only, or check mismatch.
// - single ack only after the value is accepted and applied.
// - after answered full write, a write may start at stx without address.
// - short re-write unusable once another drive addressed or no answer.
// - protected mode setting 0..2; 0 ascii default, 1 modbus rtu.
// - char is start, seven data bits lsb first, even parity, stop.
// - eot 04, enq 05, stx 02, etx 03, ack 06, nak 15, bs 08 hex.
// - group or all-group address: act but never transmit an answer.
// - read is eot, address, 4 digits, enq; reply stx, param, data, etx, check.
module ascii_param_link_engine
(
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic [1:0]  comm_mode,
  input  wire logic [6:0]  own_group_digit,
  input  wire logic [6:0]  own_unit_digit,
  input  wire logic        rx_valid,
  input  wire logic [6:0]  rx_data,
  input  wire logic        rx_parity_err,
  output logic             tx_valid,
  output logic [6:0]       tx_data,
  input  wire logic        tx_ready,
  input  wire logic        uart_tx_busy,
  output logic             line_drive_en,
  output logic             rd_req,
  output logic             wr_req,
  output logic [27:0]      param_id,
  output logic [48:0]      param_data,
  output logic [2:0]       param_len,
  input  wire logic        rd_done,
  input  wire logic        rd_ok,
  input  wire logic [48:0] rd_data,
  input  wire logic [2:0]  rd_len,
  input  wire logic        wr_done,
  input  wire logic        wr_ok
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // fold the xor result out of the control range
  function automatic logic [6:0] fold(input logic [6:0] x);
    fold = (x < ascii_link_pkg::BCC_LIFT) ? x + ascii_link_pkg::BCC_LIFT : x;
  endfunction

  // step the two parameter digits up or down, wrapping 00..99
  function automatic logic [13:0] step(input logic [13:0] p, input logic up);
    logic [6:0] hi;
    logic [6:0] lo;
    hi = p[13:7];
    lo = p[6:0];
    if (up)
    begin
      lo = (lo == ascii_link_pkg::DIGIT_9) ? ascii_link_pkg::DIGIT_0 : lo + 7'h01;
      if (lo == ascii_link_pkg::DIGIT_0)
        hi = (hi == ascii_link_pkg::DIGIT_9) ? ascii_link_pkg::DIGIT_0 : hi + 7'h01;
    end
    else
    begin
      if (lo == ascii_link_pkg::DIGIT_0)
        hi = (hi == ascii_link_pkg::DIGIT_0) ? ascii_link_pkg::DIGIT_9 : hi - 7'h01;
      lo = (lo == ascii_link_pkg::DIGIT_0) ? ascii_link_pkg::DIGIT_9 : lo - 7'h01;
    end
    step = {hi, lo};
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  ascii_link_pkg::state_t state_q, state_d;
  logic [3:0][6:0] addr_q, addr_d;
  logic [3:0][6:0] id_q, id_d;
  logic [6:0][6:0] data_q, data_d;
  logic [2:0]      cnt_q, cnt_d;
  logic [3:0]      dlen_q, dlen_d;
  logic [6:0]      acc_q, acc_d;
  logic            wr_q, wr_d;
  logic            bcast_q, bcast_d;
  logic            rewr_ok_q, rewr_ok_d;
  logic            rerd_ok_q, rerd_ok_d;
  logic            full_q, full_d;
  logic [6:0]      single_q, single_d;
  logic [3:0]      tidx_q, tidx_d;
  logic            rdq_q, rdq_d;
  logic            wrq_q, wrq_d;
  logic            drv_q, drv_d;
  logic            push;
  logic [6:0]      push_ch;
  logic            buf_ready;
  logic [3:0]      last_idx;
  logic            active;
  logic            adr_ok;
  logic            adr_unit;
  logic            adr_grp;

  assign active = (comm_mode == ascii_link_pkg::MODE_ASCII);
  assign last_idx = ascii_link_pkg::TX_DATA0 + dlen_q + 4'h1;

  // address check on the fourth digit, using the live char as unit copy
  always_comb
  begin
    adr_ok   = (addr_q[0] == addr_q[1]) && (addr_q[2] == rx_data);
    adr_unit = (addr_q[0] == own_group_digit) && (rx_data == own_unit_digit);
    adr_grp  = (rx_data == ascii_link_pkg::DIGIT_0)
               && ((addr_q[0] == own_group_digit) || (addr_q[0] == ascii_link_pkg::DIGIT_0));
  end

  // ------------------------------------------------------------
  // message engine
  // ------------------------------------------------------------
  // next values; rx chars are ignored while replying (half duplex)
  always_comb
  begin
    state_d   = state_q;
    addr_d    = addr_q;
    id_d      = id_q;
    data_d    = data_q;
    cnt_d     = cnt_q;
    dlen_d    = dlen_q;
    acc_d     = acc_q;
    wr_d      = wr_q;
    bcast_d   = bcast_q;
    rewr_ok_d = rewr_ok_q;
    rerd_ok_d = rerd_ok_q;
    full_d    = full_q;
    single_d  = single_q;
    tidx_d    = tidx_q;
    rdq_d     = rdq_q;
    wrq_d     = wrq_q;
    drv_d     = drv_q;
    push      = 1'b0;
    push_ch   = single_q;
    unique case (state_q)
      ascii_link_pkg::ST_TX, ascii_link_pkg::ST_DRAIN,
      ascii_link_pkg::ST_RDW, ascii_link_pkg::ST_WRW: ;
      default:
      begin
        if (rx_valid && rx_parity_err)
          state_d = ascii_link_pkg::ST_IDLE;
        else if (rx_valid && rx_data == ascii_link_pkg::EOT_C)
        begin
          state_d = ascii_link_pkg::ST_ADDR;
          cnt_d   = 3'h0;
        end
      end
    endcase
    unique case (state_q)
      ascii_link_pkg::ST_IDLE:
      begin
        if (rx_valid && !rx_parity_err && rx_data == ascii_link_pkg::STX_C && rewr_ok_q)
        begin
          state_d = ascii_link_pkg::ST_PARAM;
          wr_d    = 1'b1;
          bcast_d = 1'b0;
          cnt_d   = 3'h0;
          acc_d   = 7'h00;
        end
        else if (rx_valid && !rx_parity_err && rerd_ok_q
                 && (rx_data == ascii_link_pkg::NAK_C || rx_data == ascii_link_pkg::ACK_C
                     || rx_data == ascii_link_pkg::BS_C))
        begin
          if (rx_data != ascii_link_pkg::NAK_C)
            {id_d[2], id_d[3]} = step({id_q[2], id_q[3]}, rx_data == ascii_link_pkg::ACK_C);
          rdq_d   = 1'b1;
          state_d = ascii_link_pkg::ST_RDW;
        end
      end
      ascii_link_pkg::ST_ADDR:
      begin
        if (rx_valid && !rx_parity_err && rx_data != ascii_link_pkg::EOT_C)
        begin
          addr_d[cnt_q] = rx_data;
          cnt_d         = cnt_q + 3'h1;
          if (cnt_q == ascii_link_pkg::ADDR_LAST)
          begin
            rewr_ok_d = 1'b0;
            rerd_ok_d = 1'b0;
            bcast_d   = !adr_unit;
            state_d   = (adr_ok && (adr_unit || adr_grp))
                        ? ascii_link_pkg::ST_POST : ascii_link_pkg::ST_IDLE;
          end
        end
      end
      ascii_link_pkg::ST_POST:
      begin
        if (rx_valid && !rx_parity_err && rx_data != ascii_link_pkg::EOT_C)
        begin
          cnt_d   = 3'h0;
          acc_d   = 7'h00;
          wr_d    = (rx_data == ascii_link_pkg::STX_C);
          state_d = ascii_link_pkg::ST_PARAM;
          if (rx_data != ascii_link_pkg::STX_C)
          begin
            id_d[0] = rx_data;
            cnt_d   = 3'h1;
          end
        end
      end
      ascii_link_pkg::ST_PARAM:
      begin
        if (rx_valid && !rx_parity_err && rx_data != ascii_link_pkg::EOT_C)
        begin
          id_d[cnt_q] = rx_data;
          acc_d       = acc_q ^ rx_data;
          cnt_d       = cnt_q + 3'h1;
          dlen_d      = 4'h0;
          if (cnt_q == ascii_link_pkg::PARAM_LAST)
            state_d = wr_q ? ascii_link_pkg::ST_DATA : ascii_link_pkg::ST_ENQ;
        end
      end
      ascii_link_pkg::ST_ENQ:
      begin
        if (rx_valid && !rx_parity_err && rx_data != ascii_link_pkg::EOT_C)
        begin
          state_d = ascii_link_pkg::ST_IDLE;
          if (rx_data == ascii_link_pkg::ENQ_C && !bcast_q)
          begin
            rdq_d   = 1'b1;
            state_d = ascii_link_pkg::ST_RDW;
          end
        end
      end
      ascii_link_pkg::ST_DATA:
      begin
        if (rx_valid && !rx_parity_err && rx_data != ascii_link_pkg::EOT_C)
        begin
          acc_d = acc_q ^ rx_data;
          if (rx_data == ascii_link_pkg::ETX_C)
            state_d = ascii_link_pkg::ST_BCC;
          else if (dlen_q != 4'(ascii_link_pkg::DATA_MAX + 1))
          begin
            if (dlen_q < 4'(ascii_link_pkg::DATA_MAX))
              data_d[dlen_q[2:0]] = rx_data;
            dlen_d = dlen_q + 4'h1;
          end
        end
      end
      ascii_link_pkg::ST_BCC:
      begin
        if (rx_valid && !rx_parity_err && rx_data != ascii_link_pkg::EOT_C)
        begin
          if (rx_data == fold(acc_q) && dlen_q != 4'h0
              && dlen_q <= 4'(ascii_link_pkg::DATA_MAX))
          begin
            wrq_d   = 1'b1;
            state_d = ascii_link_pkg::ST_WRW;
          end
          else
          begin
            single_d = ascii_link_pkg::NAK_C;
            full_d   = 1'b0;
            tidx_d   = 4'h0;
            drv_d    = !bcast_q;
            state_d  = bcast_q ? ascii_link_pkg::ST_IDLE : ascii_link_pkg::ST_TX;
            rewr_ok_d = !bcast_q;
          end
        end
      end
      ascii_link_pkg::ST_WRW:
      begin
        if (wr_done)
        begin
          wrq_d     = 1'b0;
          single_d  = wr_ok ? ascii_link_pkg::ACK_C : ascii_link_pkg::NAK_C;
          full_d    = 1'b0;
          tidx_d    = 4'h0;
          drv_d     = !bcast_q;
          rewr_ok_d = !bcast_q;
          state_d   = bcast_q ? ascii_link_pkg::ST_IDLE : ascii_link_pkg::ST_TX;
        end
      end
      ascii_link_pkg::ST_RDW:
      begin
        if (rd_done)
        begin
          rdq_d    = 1'b0;
          full_d   = rd_ok;
          single_d = ascii_link_pkg::EOT_C;
          data_d   = rd_data;
          dlen_d   = {1'b0, rd_len};
          acc_d    = 7'h00;
          tidx_d   = 4'h0;
          drv_d    = 1'b1;
          state_d  = ascii_link_pkg::ST_TX;
        end
      end
      ascii_link_pkg::ST_TX:
      begin
        if (buf_ready)
        begin
          push = 1'b1;
          if (!full_q)
            push_ch = single_q;
          else if (tidx_q == 4'h0)
            push_ch = ascii_link_pkg::STX_C;
          else if (tidx_q < ascii_link_pkg::TX_DATA0)
            push_ch = id_q[tidx_q[1:0] - 2'h1];
          else if (tidx_q < last_idx - 4'h1)
            push_ch = data_q[3'(tidx_q - ascii_link_pkg::TX_DATA0)];
          else if (tidx_q == last_idx - 4'h1)
            push_ch = ascii_link_pkg::ETX_C;
          else
            push_ch = fold(acc_q);
          if (tidx_q != 4'h0)
            acc_d = acc_q ^ push_ch;
          tidx_d = tidx_q + 4'h1;
          if (!full_q || tidx_q == last_idx)
          begin
            state_d   = ascii_link_pkg::ST_DRAIN;
            rerd_ok_d = full_q;
          end
        end
      end
      ascii_link_pkg::ST_DRAIN:
      begin
        if (!tx_valid && !uart_tx_busy)
        begin
          drv_d   = 1'b0;
          state_d = ascii_link_pkg::ST_IDLE;
        end
      end
      default: state_d = ascii_link_pkg::ST_IDLE;
    endcase
    if (!active)
    begin
      state_d   = ascii_link_pkg::ST_IDLE;
      rewr_ok_d = 1'b0;
      rerd_ok_d = 1'b0;
      rdq_d     = 1'b0;
      wrq_d     = 1'b0;
      drv_d     = 1'b0;
      push      = 1'b0;
    end
  end

  // engine registers
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      state_q   <= ascii_link_pkg::ST_IDLE;
      addr_q    <= '0;
      id_q      <= '0;
      data_q    <= '0;
      cnt_q     <= 3'h0;
      dlen_q    <= 4'h0;
      acc_q     <= 7'h00;
      wr_q      <= 1'b0;
      bcast_q   <= 1'b0;
      rewr_ok_q <= 1'b0;
      rerd_ok_q <= 1'b0;
      full_q    <= 1'b0;
      single_q  <= ascii_link_pkg::NAK_C;
      tidx_q    <= 4'h0;
      rdq_q     <= 1'b0;
      wrq_q     <= 1'b0;
      drv_q     <= 1'b0;
    end
    else
    begin
      state_q   <= state_d;
      addr_q    <= addr_d;
      id_q      <= id_d;
      data_q    <= data_d;
      cnt_q     <= cnt_d;
      dlen_q    <= dlen_d;
      acc_q     <= acc_d;
      wr_q      <= wr_d;
      bcast_q   <= bcast_d;
      rewr_ok_q <= rewr_ok_d;
      rerd_ok_q <= rerd_ok_d;
      full_q    <= full_d;
      single_q  <= single_d;
      tidx_q    <= tidx_d;
      rdq_q     <= rdq_d;
      wrq_q     <= wrq_d;
      drv_q     <= drv_d;
    end
  end

  assign rd_req        = rdq_q;
  assign wr_req        = wrq_q;
  assign param_id      = id_q;
  assign param_data    = data_q;
  assign param_len     = dlen_q[2:0];
  assign line_drive_en = drv_q;

  // ------------------------------------------------------------
  // two-entry transmit buffer
  // ------------------------------------------------------------
  // head feeds the uart directly so a stall never drops a char
  logic       hv_q, hv_d, tv_q, tv_d;
  logic [6:0] hd_q, hd_d, td_q, td_d;

  assign buf_ready = !tv_q;

  always_comb
  begin
    hv_d = hv_q;
    tv_d = tv_q;
    hd_d = hd_q;
    td_d = td_q;
    if (hv_q && tx_ready)
    begin
      hv_d = tv_q;
      hd_d = td_q;
      tv_d = 1'b0;
    end
    if (push && !hv_d)
    begin
      hv_d = 1'b1;
      hd_d = push_ch;
    end
    else if (push)
    begin
      tv_d = 1'b1;
      td_d = push_ch;
    end
  end

  // buffer registers
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      hv_q <= 1'b0;
      tv_q <= 1'b0;
      hd_q <= 7'h00;
      td_q <= 7'h00;
    end
    else
    begin
      hv_q <= hv_d;
      tv_q <= tv_d;
      hd_q <= hd_d;
      td_q <= td_d;
    end
  end

  assign tx_valid = hv_q;
  assign tx_data  = hd_q;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  bcc_range_a: assert property (push && full_q && tidx_q == last_idx |-> push_ch >= 7'h20)
    else $error("check char in control range");
  bcast_quiet_a: assert property (state_q == ascii_link_pkg::ST_TX |-> !bcast_q || full_q)
    else $error("reply to a group address");
  drive_cover_a: assert property (tx_valid |-> line_drive_en)
    else $error("char offered with line released");
  bad_check_a: assert property (state_q == ascii_link_pkg::ST_BCC && rx_valid && !rx_parity_err && active
    && rx_data != ascii_link_pkg::EOT_C && rx_data != fold(acc_q) && !bcast_q
    |=> state_q == ascii_link_pkg::ST_TX && single_q == ascii_link_pkg::NAK_C)
    else $error("bad check not refused");
  ack_late_a: assert property (state_q == ascii_link_pkg::ST_WRW && wr_done && wr_ok && !bcast_q && active
    |=> single_q == ascii_link_pkg::ACK_C ##1 tx_valid)
    else $error("ack not sent after applied write");
  data_len_a: assert property (wr_req |-> param_len != 3'h0 && dlen_q <= 4'h7)
    else $error("write with illegal data length");
  addr_split_a: assert property (state_q == ascii_link_pkg::ST_ADDR && rx_valid && !rx_parity_err
    && cnt_q == 3'h3 && rx_data != addr_q[2] && rx_data != ascii_link_pkg::EOT_C
    |=> state_q == ascii_link_pkg::ST_IDLE
    ##1 (state_q == ascii_link_pkg::ST_IDLE || state_q == ascii_link_pkg::ST_ADDR))
    else $error("mismatched address accepted");
  reread_a: assert property (state_q == ascii_link_pkg::ST_IDLE && rx_valid && !rx_parity_err && active
    && rerd_ok_q && rx_data == ascii_link_pkg::ACK_C |=> rd_req && param_id[27:14] != $past(param_id[27:14]))
    else $error("next-parameter re-read missed");
  mode_gate_a: assert property (!active |=> state_q == ascii_link_pkg::ST_IDLE && !line_drive_en)
    else $error("engine active outside ascii mode");

  write_done_c: cover property (state_q == ascii_link_pkg::ST_WRW ##1 state_q == ascii_link_pkg::ST_TX);
  read_reply_c: cover property (push && full_q && tidx_q == last_idx);
  stall_full_c: cover property (tv_q && !tx_ready);
endmodule

// *** sim/link_far_side_model.sv ***
// parameter store and uart transmitter model facing the link engine
module link_far_side_model
(
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        tx_valid,
  input  wire logic [6:0]  tx_data,
  output logic             tx_ready,
  output logic             uart_tx_busy,
  input  wire logic        rd_req,
  input  wire logic        wr_req,
  input  wire logic [27:0] param_id,
  input  wire logic [48:0] param_data,
  input  wire logic [2:0]  param_len,
  output logic             rd_done,
  output logic             rd_ok,
  output logic [48:0]      rd_data,
  output logic [2:0]       rd_len,
  output logic             wr_done,
  output logic             wr_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // store and transmitter
  // ------------------------------------------------------------
  localparam logic [48:0] REPLY_DATA = {7'h36, 7'h2E, 7'h37, 7'h34, 7'h30, 7'h30, 7'h2D};
  logic [6:0]  got[$];
  int          n_wr      = 0;
  logic [27:0] last_id   = 28'h000_0000;
  logic [48:0] last_data;
  logic [2:0]  last_len  = 3'h0;
  logic [1:0]  wait_cnt  = 2'h0;
  logic        seen      = 1'b0;
  logic        pace      = 1'b0;
  logic [3:0]  busy_cnt  = 4'h0;
  logic        ok_val;
  initial rd_done = 1'b0;
  initial wr_done = 1'b0;
  // answers off the strobe show inverted junk and a zero length, not the last value
  assign ok_val  = (param_id[27:21] != 7'h39);
  assign wr_ok   = wr_done ? ok_val : ~ok_val;
  assign rd_ok   = rd_done ? ok_val : ~ok_val;
  assign rd_data = rd_done ? REPLY_DATA : ~REPLY_DATA;
  assign rd_len  = rd_done ? 3'h7 : 3'h0;
  // store answers four cycles after a request, value applied at done
  always @(posedge core_clk)
  begin
    rd_done <= 1'b0;
    wr_done <= 1'b0;
    if (srst || !(rd_req || wr_req))
    begin
      seen     <= 1'b0;
      wait_cnt <= 2'h0;
    end
    else if (!seen)
    begin
      wait_cnt <= wait_cnt + 2'h1;
      if (wait_cnt == 2'h3)
      begin
        seen    <= 1'b1;
        rd_done <= rd_req;
        wr_done <= wr_req;
        if (wr_req)
        begin
          n_wr      <= n_wr + 1;
          last_id   <= param_id;
          last_data <= param_data;
          last_len  <= param_len;
        end
      end
    end
  end
  // one char at a time; a stall on every other cycle tests the buffer
  assign tx_ready     = (busy_cnt == 4'h0) && pace;
  assign uart_tx_busy = (busy_cnt != 4'h0);
  always @(posedge core_clk)
  begin
    pace <= !pace;
    if (busy_cnt != 4'h0)
      busy_cnt <= busy_cnt - 4'h1;
    if (tx_valid && tx_ready)
    begin
      got.push_back(tx_data);
      busy_cnt <= 4'h6;
    end
  end
endmodule

// *** sim/ascii_param_link_engine_test.sv ***
// self-checking bench of the ascii parameter link engine
module ascii_param_link_engine_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // signals, design and far side
  // ------------------------------------------------------------
  logic        core_clk  = 1'b0;
  logic        srst      = 1'b1;
  logic [1:0]  comm_mode = 2'h0;
  logic        rx_valid  = 1'b0;
  logic [6:0]  rx_data   = 7'h00;
  logic        rx_perr   = 1'b0;
  logic [6:0]  grp_digit = 7'h32;
  logic [6:0]  unit_dig  = 7'h36;
  logic        tx_valid, tx_ready, uart_tx_busy, line_drive_en;
  logic        rd_req, wr_req, rd_done, rd_ok, wr_done, wr_ok;
  logic [6:0]  tx_data;
  logic [27:0] param_id;
  logic [48:0] param_data, rd_data;
  logic [2:0]  param_len, rd_len;
  int          n_errors  = 0;
  int          checked   = 0;
  always #5 core_clk = ~core_clk;
  ascii_param_link_engine uut (.core_clk(core_clk), .srst(srst), .comm_mode(comm_mode),
    .own_group_digit(grp_digit), .own_unit_digit(unit_dig), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_parity_err(rx_perr), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .uart_tx_busy(uart_tx_busy), .line_drive_en(line_drive_en), .rd_req(rd_req), .wr_req(wr_req),
    .param_id(param_id), .param_data(param_data), .param_len(param_len), .rd_done(rd_done),
    .rd_ok(rd_ok), .rd_data(rd_data), .rd_len(rd_len), .wr_done(wr_done), .wr_ok(wr_ok));
  link_far_side_model store (.core_clk(core_clk), .srst(srst), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .uart_tx_busy(uart_tx_busy), .rd_req(rd_req), .wr_req(wr_req),
    .param_id(param_id), .param_data(param_data), .param_len(param_len), .rd_done(rd_done),
    .rd_ok(rd_ok), .rd_data(rd_data), .rd_len(rd_len), .wr_done(wr_done), .wr_ok(wr_ok));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic give_verdict;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  // check char worked out independently of the design
  function automatic string bcc_of(input string s);
    logic [6:0] acc;
    string      r;
    acc = 7'(s[0]);
    for (int i = 1; i < s.len(); i++)
      acc = acc ^ 7'(s[i]);
    acc = acc ^ ascii_link_pkg::ETX_C;
    if (acc < 7'h20)
      acc = acc + ascii_link_pkg::BCC_LIFT;
    r = " ";
    r[0] = byte'(acc);
    return r;
  endfunction
  function automatic logic [48:0] pack(input string s);
    logic [48:0] v;
    v = '0;
    for (int k = 0; k < s.len(); k++)
      v[7*k+:7] = 7'(s[k]);
    return v;
  endfunction
  function automatic string wr_msg(input string addr, input string body);
    return {addr == "" ? "" : {"\004", addr}, "\002", body, "\003", bcc_of(body)};
  endfunction
  function automatic string rd_reply(input string p);
    return {"\002", p, "-0047.6", "\003", bcc_of({p, "-0047.6"})};
  endfunction
  // chars go back to back, strobe held high across the message
  task automatic send(input string s);
    store.got.delete();
    for (int i = 0; i < s.len(); i++)
    begin
      rx_data  = 7'(s[i]);
      rx_valid = 1'b1;
      tick(1);
    end
    rx_valid = 1'b0;
  endtask
  // an empty expectation means the line must stay silent
  task automatic expect_reply(input string exp, input string what);
    int    n;
    string s;
    string c;
    n = 0;
    while ((store.got.size() < exp.len() || line_drive_en !== 1'b0) && n < 400)
    begin
      tick(1);
      n++;
    end
    if (n >= 400)
    begin
      n_errors++;
      $display("[FAIL] %0t %s timed out", $time, what);
      give_verdict();
    end
    tick(30);
    s = "";
    c = " ";
    foreach (store.got[i])
    begin
      c[0] = byte'(store.got[i]);
      s = {s, c};
    end
    check(s == exp, what);
    check(line_drive_en === 1'b0, "line left driven");
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_write_ok;
    logic [48:0] v;
    v = pack("+76.4");
    send(wr_msg("2266", "0125+76.4"));
    expect_reply("\006", "write not acked");
    check(store.last_id === 28'(pack("0125")), "param id");
    check(store.last_len === 3'h5, "data length");
    check(store.last_data[34:0] === v[34:0], "data chars");
  endtask
  task automatic t_write_naks;
    send({"\004", "2266", "\002", "0125+76.4", "\003", "4"});
    expect_reply("\025", "bad check char");
    send(wr_msg("", "011212"));
    expect_reply("\006", "short rewrite with folded check");
    send(wr_msg("", "01291"));
    expect_reply("\025", "read-only write");
    send(wr_msg("", "012512345678"));
    expect_reply("\025", "eight data chars");
  endtask
  task automatic t_foreign;
    send(wr_msg("3377", "01251"));
    expect_reply("", "foreign address answered");
    send(wr_msg("", "01251"));
    expect_reply("", "rewrite after other drive");
    send(wr_msg("2366", "01251"));
    expect_reply("", "split address digits");
    send(wr_msg("2267", "01251"));
    expect_reply("", "split unit digits");
  endtask
  task automatic t_group;
    int n;
    n = store.n_wr;
    send(wr_msg("2200", "01251"));
    expect_reply("", "group write answered");
    check(store.n_wr == n + 1, "group write not applied");
    send(wr_msg("0000", "01251"));
    expect_reply("", "all-group write answered");
    check(store.n_wr == n + 2, "all-group write not applied");
  endtask
  task automatic t_read;
    send({"\004", "2266", "0117", "\005"});
    expect_reply(rd_reply("0117"), "read reply");
    send("\006");
    expect_reply(rd_reply("0118"), "next parameter");
    send("\010");
    expect_reply(rd_reply("0117"), "previous parameter");
    send("\025");
    expect_reply(rd_reply("0117"), "same parameter");
    send({"\004", "2266", "0119", "\005"});
    expect_reply("\004", "invalid read reply");
    send("\006");
    expect_reply("", "re-read after invalid reply");
  endtask
  task automatic t_mode;
    int n;
    for (int m = 1; m < 3; m++)
    begin
      comm_mode = 2'(m);
      n = store.n_wr;
      send(wr_msg("2266", "01251"));
      expect_reply("", "engine active outside ascii mode");
      check(store.n_wr == n, "write applied outside ascii mode");
    end
    comm_mode = 2'h0;
  endtask
  initial
  begin
    tick(2);
    srst = 1'b0;
    t_write_ok();
    t_write_naks();
    t_foreign();
    t_group();
    t_read();
    t_mode();
    give_verdict();
  end
endmodule
